// File: logic/gibs_map.vh
`ifndef GIBS_MAP_VH
`define GIBS_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define GIBS_ADDR_W 16
`define GIBS_OFS_IRQ_SUMMARY 16'h021a
`define GIBS_OFS_RSVD_A 16'h021b
`define GIBS_OFS_RSVD_B 16'h021c
`define GIBS_OFS_RSVD_C 16'h021d
`define GIBS_OFS_BOOT_FAIL 16'h021e
`define GIBS_OFS_LOAD_STATUS 16'h021f
// ----------------------------------------
// field positions
// ----------------------------------------
`define GIBS_BIT_IRQ_SUMMARY 0
`define GIBS_BIT_LOAD_FAILED 0
`define GIBS_BIT_LOAD_COMPLETE 0
`define GIBS_BIT_CHECKSUM_OK 3
// ----------------------------------------
// reset values
// ----------------------------------------
`define GIBS_RST_DATA 8'h00
`define GIBS_RST_CHECKSUM_OK 1'b1
`define GIBS_RST_FLAG 1'b0
`endif

// File: logic/gibs_sync.v
`timescale 1ns/1ns
// three-stage synchroniser for an outside level; change counts when
// the second and third stages agree
module gibs_sync (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // level in and filtered level out
    input wire async_in,
    output reg sync_out
);

reg stage_a;
reg stage_b;
reg stage_c;

// ----------------------------------------
// synchroniser chain
// ----------------------------------------
always @(posedge core_clk) begin
    if (reset) begin
        stage_a <= 1'b0;
        stage_b <= 1'b0;
        stage_c <= 1'b0;
        sync_out <= 1'b0;
    end else begin
        stage_a <= async_in;
        stage_b <= stage_a;
        stage_c <= stage_b;
        if (stage_b == stage_c) begin
            sync_out <= stage_c;
        end
    end
end

endmodule

// File: logic/gibs_status_bank.v
`timescale 1ns/1ns
`include "gibs_map.vh"
// Notes on behaviour
// - summary flag 1 and interrupt pin low while any enabled status set.
// - load-failed flag sets on eeprom read failure, holds until reset.
// - load-complete flag sets when eeprom read cycle ends, held to reset.
// - checksum-ok flag reads 0 on crc failure, else 1.
// - after checksum failure the management port stays locked until reset.
module gibs_status_bank #(
    parameter NUM_IRQ = 8
) (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // interrupt sources, raised by monitors on other clocks
    input wire [NUM_IRQ-1:0] irq_status,
    input wire [NUM_IRQ-1:0] irq_enable,
    // eeprom loader results, same clock
    input wire loader_busy,
    input wire loader_done,
    input wire loader_read_error,
    input wire loader_crc_error,
    // status read port from the management interface
    input wire rd_en,
    input wire [15:0] rd_addr,
    output reg [7:0] rd_data,
    output reg rd_valid,
    // open-drain interrupt pin
    output reg irq_pin_active_low_out,
    output reg irq_pin_active_low_oe,
    // serial management port lock
    output reg port_locked,
    // flag views
    output reg irq_summary,
    output reg eeprom_load_failed,
    output reg eeprom_load_complete,
    output reg eeprom_checksum_ok
);

// ----------------------------------------
// interrupt source capture
// ----------------------------------------
wire [NUM_IRQ-1:0] irq_status_sync;

// any enabled source that is raised
function irq_hot;
    input [NUM_IRQ-1:0] status;
    input [NUM_IRQ-1:0] enable;
    begin
        irq_hot = |(status & enable);
    end
endfunction

// sources come from monitors on other clocks, one synchroniser each
genvar g;
generate
    for (g = 0; g < NUM_IRQ; g = g + 1) begin : gen_irq_sync
        gibs_sync u_sync (
            .core_clk(core_clk),
            .reset(reset),
            .async_in(irq_status[g]),
            .sync_out(irq_status_sync[g])
        );
    end
endgenerate

// ----------------------------------------
// decode
// ----------------------------------------
function [7:0] read_mux;
    input [15:0] addr;
    input summary;
    input failed;
    input complete;
    input crc_ok;
    begin
        read_mux = `GIBS_RST_DATA;
        case (addr)
            `GIBS_OFS_IRQ_SUMMARY: begin
                read_mux[`GIBS_BIT_IRQ_SUMMARY] = summary;
            end
            `GIBS_OFS_BOOT_FAIL: begin
                read_mux[`GIBS_BIT_LOAD_FAILED] = failed;
            end
            `GIBS_OFS_LOAD_STATUS: begin
                read_mux[`GIBS_BIT_LOAD_COMPLETE] = complete;
                read_mux[`GIBS_BIT_CHECKSUM_OK] = crc_ok;
            end
            default: begin
                read_mux = `GIBS_RST_DATA; // reserved reads as zero
            end
        endcase
    end
endfunction

// ----------------------------------------
// load sequence tracking
// ----------------------------------------
localparam ST_LOADING = 2'b00;
localparam ST_RUN = 2'b01;
localparam ST_LOCKED = 2'b10;

reg [1:0] state;
reg [1:0] next_state;
wire load_end;

assign load_end = loader_done & ~loader_busy;

// state decisions after reset
always @* begin
    next_state = state;
    case (state)
        ST_LOADING: begin
            if (load_end) begin
                if (loader_crc_error) begin
                    next_state = ST_LOCKED;
                end else begin
                    next_state = ST_RUN;
                end
            end
        end
        ST_RUN: begin
            next_state = ST_RUN;
        end
        ST_LOCKED: begin
            next_state = ST_LOCKED;
        end
        default: begin
            next_state = ST_LOADING;
        end
    endcase
end

// state register
always @(posedge core_clk) begin
    if (reset) begin
        state <= ST_LOADING;
    end else begin
        state <= next_state;
    end
end

// ----------------------------------------
// boot result flags
// ----------------------------------------
// only the first load end after reset counts; later ends are ignored
wire first_end;

assign first_end = (state == ST_LOADING) & load_end;

// load-complete flag, sticky until reset
always @(posedge core_clk) begin
    if (reset) begin
        eeprom_load_complete <= `GIBS_RST_FLAG;
    end else if (first_end) begin
        eeprom_load_complete <= 1'b1;
    end
end

// load-failed flag, sticky until reset
always @(posedge core_clk) begin
    if (reset) begin
        eeprom_load_failed <= `GIBS_RST_FLAG;
    end else if (first_end && loader_read_error) begin
        eeprom_load_failed <= 1'b1;
    end
end

// checksum result, held from the first load end until reset
always @(posedge core_clk) begin
    if (reset) begin
        eeprom_checksum_ok <= `GIBS_RST_CHECKSUM_OK;
    end else if (first_end) begin
        eeprom_checksum_ok <= ~loader_crc_error;
    end
end

// ----------------------------------------
// management port lock
// ----------------------------------------
// a bad checksum keeps the port locked; only reset lets the load retry
always @(posedge core_clk) begin
    if (reset) begin
        port_locked <= `GIBS_RST_FLAG;
    end else if (first_end) begin
        port_locked <= loader_crc_error;
    end
end

// ----------------------------------------
// interrupt summary and pin
// ----------------------------------------
// summary flag as seen by register reads
always @(posedge core_clk) begin
    if (reset) begin
        irq_summary <= `GIBS_RST_FLAG;
    end else begin
        irq_summary <= irq_hot(irq_status_sync, irq_enable);
    end
end

// open-drain pin: data always low, enable pulls the line down
always @(posedge core_clk) begin
    if (reset) begin
        irq_pin_active_low_out <= 1'b0;
        irq_pin_active_low_oe <= 1'b0;
    end else begin
        irq_pin_active_low_out <= 1'b0;
        irq_pin_active_low_oe <= irq_hot(irq_status_sync, irq_enable);
    end
end

// ----------------------------------------
// status read port
// ----------------------------------------
// fixed one-cycle answer; the valid strobe follows rd_en one cycle later
always @(posedge core_clk) begin
    if (reset) begin
        rd_valid <= 1'b0;
    end else begin
        rd_valid <= rd_en;
    end
end

// read data register, holds until the next read
always @(posedge core_clk) begin
    if (reset) begin
        rd_data <= `GIBS_RST_DATA;
    end else if (rd_en) begin
        rd_data <= read_mux(rd_addr, irq_summary, eeprom_load_failed,
            eeprom_load_complete, eeprom_checksum_ok);
    end
end

endmodule

// File: tb/gibs_props.sv
`timescale 1ns/1ns
module gibs_props #(
    parameter NUM_IRQ = 8
) (
    // inputs
    input wire core_clk,
    input wire reset,
    input wire [NUM_IRQ-1:0] irq_status,
    input wire [NUM_IRQ-1:0] irq_enable,
    input wire loader_busy,
    input wire loader_done,
    input wire loader_read_error,
    input wire loader_crc_error,
    // outputs
    input wire irq_summary,
    input wire irq_pin_active_low_oe,
    input wire port_locked,
    input wire eeprom_load_failed,
    input wire eeprom_load_complete,
    input wire eeprom_checksum_ok
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // load end seen
    wire fin = loader_done && !loader_busy;
    // edges since reset, for the synchroniser delay on the sources
    reg [2:0] age;
    always @(posedge core_clk) begin
        if (reset) begin
            age <= 3'h0;
        end else if (age != 3'h7) begin
            age <= age + 3'h1;
        end
    end
    // first load end after reset
    sequence first;
        !eeprom_load_complete && fin;
    endsequence
    // source level steady over the last two synchroniser stages
    sequence settled;
        age >= 3'h5 && $past(irq_status, 4) == $past(irq_status, 5);
    endsequence
    AST_IRQ: assert property (
        settled |->
            irq_summary == |($past(irq_status, 5) & $past(irq_enable)) &&
            irq_pin_active_low_oe ==
                |($past(irq_status, 5) & $past(irq_enable)))
        else $error("irq");
    AST_FAIL: assert property (
        eeprom_load_failed |=> eeprom_load_failed) else $error("failed");
    AST_FAIL_SET: assert property (
        first |=> eeprom_load_failed == $past(loader_read_error))
        else $error("failed set");
    AST_DONE: assert property (
        first |=> eeprom_load_complete) else $error("complete");
    AST_CRC: assert property (
        first |=> eeprom_checksum_ok != $past(loader_crc_error))
        else $error("crc");
    AST_LOCK: assert property (
        first ##0 loader_crc_error |=> port_locked [*2]) else $error("lock");
    AST_QUIET: assert property (
        !fin |=> $stable(eeprom_load_complete) && $stable(port_locked)
            && $stable(eeprom_load_failed) && $stable(eeprom_checksum_ok))
        else $error("quiet");
endmodule
bind gibs_status_bank gibs_props #(.NUM_IRQ(NUM_IRQ)) u_props (
    .core_clk(core_clk),
    .reset(reset),
    .irq_status(irq_status),
    .irq_enable(irq_enable),
    .loader_busy(loader_busy),
    .loader_done(loader_done),
    .loader_read_error(loader_read_error),
    .loader_crc_error(loader_crc_error),
    .irq_summary(irq_summary),
    .irq_pin_active_low_oe(irq_pin_active_low_oe),
    .port_locked(port_locked),
    .eeprom_load_failed(eeprom_load_failed),
    .eeprom_load_complete(eeprom_load_complete),
    .eeprom_checksum_ok(eeprom_checksum_ok)
);

// File: tb/gibs_host.sv
`timescale 1ns/1ns
module gibs_host (
    // clock and answer
    input wire core_clk,
    input wire rd_valid,
    input wire [7:0] rd_data,
    // request
    output reg rd_en,
    output reg [15:0] rd_addr
);
    initial begin
        rd_en = 0;
        rd_addr = 16'h0000;
    end
    // one read: pulse, answer taken on the valid edge
    task rd(input [15:0] a, output [7:0] d);
        begin
            @(posedge core_clk) #1 rd_en = 1;
            rd_addr = a;
            @(posedge core_clk) #1 rd_en = 0;
            @(posedge core_clk) d = rd_valid ? rd_data : 8'hxx;
            #1; // hand back off the edge
        end
    endtask
endmodule

// File: tb/gibs_status_bank_bench.sv
`timescale 1ns/1ns
module gibs_status_bank_bench;
    reg clk = 0, rst = 1, by = 0, dn = 0, re = 0, ce = 0;
    reg [7:0] st = 0, en = 0, d;
    reg [16:0] rows [0:3];
    wire v, rdv, po, oe, lk, sm, fl, cp, ok;
    wire [15:0] a;
    wire [7:0] q;
    integer fails = 0, n_tests = 0, i;
    always #4 clk = ~clk;
    gibs_status_bank uut (.core_clk(clk), .reset(rst), .irq_status(st),
        .irq_enable(en), .loader_busy(by), .loader_done(dn),
        .loader_read_error(re), .loader_crc_error(ce), .rd_en(v),
        .rd_addr(a), .rd_data(q), .rd_valid(rdv),
        .irq_pin_active_low_out(po), .irq_pin_active_low_oe(oe),
        .port_locked(lk), .irq_summary(sm), .eeprom_load_failed(fl),
        .eeprom_load_complete(cp), .eeprom_checksum_ok(ok));
    gibs_host host (.core_clk(clk), .rd_valid(rdv), .rd_data(q),
        .rd_en(v), .rd_addr(a));
    task chk(input [7:0] g, input [7:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("BAD %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d bad %0d", n_tests, fails);
            if (fails == 0 && n_tests > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    // busy cycle, then one end with the given qualifiers
    task load(input r, input c);
        begin
            @(posedge clk) #1 by = 1;
            @(posedge clk) #1 by = 0;
            dn = 1;
            re = r;
            ce = c;
            @(posedge clk) #1 dn = 0;
        end
    endtask
    task reboot;
        begin
            rst = 1;
            repeat (10) @(posedge clk);
            #1 rst = 0;
        end
    endtask
    // watchdog
    initial begin
        #20000;
        fails = fails + 1;
        tally_and_finish;
    end
    initial begin
        rows[0] = {8'h01, 8'h01, 1'b1};
        rows[1] = {8'h80, 8'h7f, 1'b0};
        rows[2] = {8'hf0, 8'h10, 1'b1};
        rows[3] = {8'h00, 8'hff, 1'b0};
        reboot;
        chk({4'h0, fl, cp, ok, lk}, 8'h02);
        for (i = 0; i < 4; i = i + 1) begin
            {st, en} = rows[i][16:1];
            // sources settle through the synchroniser before the summary
            repeat (5) @(posedge clk);
            #1 chk({po, oe, sm}, {1'b0, {2{rows[i][0]}}});
            host.rd(16'h021a, d);
            chk(d & 8'h01, {7'h00, rows[i][0]});
        end
        $display("irq done");
        load(0, 1);
        load(1, 0);
        chk({4'h0, fl, cp, ok, lk}, 8'h05);
        host.rd(16'h021f, d);
        chk(d & 8'h09, 8'h01);
        reboot;
        chk({4'h0, fl, cp, ok, lk}, 8'h02);
        load(1, 0);
        load(0, 1);
        chk({4'h0, fl, cp, ok, lk}, 8'h0e);
        host.rd(16'h021e, d);
        chk(d & 8'h01, 8'h01);
        reboot;
        chk({4'h0, fl, cp, ok, lk}, 8'h02);
        $display("loader done");
        tally_and_finish;
    end
endmodule
